// [acr_pkg.sv]
// ****************************************************************
// Constants
// ****************************************************************
package acr_pkg;
    localparam int unsigned ADDR_W        = 10;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned NUM_SLOTS     = 32;
    localparam int unsigned RES_W         = 10;
    localparam int unsigned RES_LSB_W     = 3;
    localparam int unsigned RES_MSB_W     = 7;

    // Register map
    localparam logic [9:0]  ADDR_CTRL2    = 10'h061;
    localparam logic [9:0]  ADDR_GAIN4    = 10'h063;
    localparam logic [9:0]  ADDR_EXT      = 10'h1de;
    localparam logic [4:0]  BASE_HIGH_HI  = 5'h08;   // 0x100..0x11f
    localparam logic [4:0]  BASE_LOW_HI   = 5'h09;   // 0x120..0x13f
    localparam logic [4:0]  BASE_SEL_HI   = 5'h0a;   // 0x140..0x15f
    localparam logic [7:0]  EXT_RESET     = 8'h00;
    localparam logic [7:0]  READ_ZERO     = 8'h00;

    // Field positions
    localparam int unsigned CH20_GAIN_BIT = 2;
    localparam int unsigned CH21_GAIN_BIT = 3;
    localparam int unsigned SLOT_GAIN_BIT = 7;
    localparam int unsigned SEL_CH_W      = 5;
    localparam int unsigned SEL_X_BIT     = 5;
    localparam int unsigned SEL_Y_BIT     = 6;
    localparam int unsigned SEL_CROSS_BIT = 7;
    localparam int unsigned SUPPLY_BIT    = 0;
    localparam int unsigned CHARGE_BIT    = 1;
    localparam int unsigned BACKUP_BIT    = 2;
    localparam int unsigned LSBW_BIT      = 4;
    localparam int unsigned SLEEP_W       = 3;
    localparam int unsigned GO_BIT        = 6;

    localparam logic [4:0]  CH_GAIN20     = 5'h14;
    localparam logic [4:0]  CH_GAIN21     = 5'h15;
    localparam logic [4:0]  LAST_SLOT     = 5'h1f;
    localparam logic [2:0]  SLEEP_CONT    = 3'h0;
    localparam logic [2:0]  SLEEP_NONE    = 3'h7;

    // Timing
    localparam int unsigned CLK_MHZ       = 125;
    localparam int unsigned SLEEP_UNIT_US = 4500;
    localparam int unsigned UNIT_CYCLES   = SLEEP_UNIT_US * CLK_MHZ;

    // Serial frame
    localparam logic [4:0]  FRAME_BITS    = 5'h18;
    localparam logic [4:0]  HDR_BITS      = 5'h10;
    localparam int unsigned FRM_WE_BIT    = 23;
    localparam int unsigned HDR_WE_BIT    = 15;
    localparam int unsigned HDR_ADDR_LSB  = 5;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_REQ   = 2'b01,
        ST_WAIT  = 2'b10,
        ST_PAUSE = 2'b11
    } acr_state_t;
endpackage : acr_pkg

// [acr_spi_slave.sv]
`timescale 1ns/1ps
// ****************************************************************
// Serial register port, mode 0, oversampled on mclk
// ****************************************************************
module acr_spi_slave (
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    input  wire logic                         spi_cs_n,
    input  wire logic                         spi_sclk,
    input  wire logic                         spi_mosi,
    output logic                              spi_miso_o,
    output logic                              spi_miso_oe,
    output logic [acr_pkg::ADDR_W-1:0]        reg_addr,
    output logic [acr_pkg::DATA_W-1:0]        reg_wdata,
    output logic                              reg_we,
    output logic                              reg_re,
    input  wire logic [acr_pkg::DATA_W-1:0]   reg_rdata
);
    typedef struct packed {
        logic        cs_s1, cs_s2, ck_s1, ck_s2, ck_s3, mo_s1, mo_s2;
        logic [4:0]  cnt;
        logic [23:0] sh;
        logic [7:0]  tx;
        logic        ld, miso, we, re;
        logic [9:0]  addr;
        logic [7:0]  wdata;
    } acr_spi_t;

    acr_spi_t q, d;
    logic [23:0] nsh;

    always_comb begin
        d      = q;
        nsh    = {q.sh[22:0], q.mo_s2};
        d.we   = 1'b0;
        d.re   = 1'b0;
        d.ld   = q.re;
        d.cs_s1 = spi_cs_n;
        d.cs_s2 = q.cs_s1;
        d.ck_s1 = spi_sclk;
        d.ck_s2 = q.ck_s1;
        d.ck_s3 = q.ck_s2;
        d.mo_s1 = spi_mosi;
        d.mo_s2 = q.mo_s1;
        if (q.ld) begin
            d.tx = reg_rdata;
        end
        if (q.cs_s2) begin
            d.cnt  = 5'h00;
            d.miso = 1'b0;
        end else if (q.ck_s2 && !q.ck_s3 && q.cnt < acr_pkg::FRAME_BITS) begin
            d.sh  = nsh;
            d.cnt = q.cnt + 5'h01;
            if (q.cnt == acr_pkg::HDR_BITS - 5'h01) begin
                d.addr = nsh[acr_pkg::HDR_ADDR_LSB +: acr_pkg::ADDR_W];
                d.re   = !nsh[acr_pkg::HDR_WE_BIT];
            end
            if (q.cnt == acr_pkg::FRAME_BITS - 5'h01) begin
                d.we    = nsh[acr_pkg::FRM_WE_BIT];
                d.wdata = nsh[acr_pkg::DATA_W-1:0];
            end
        end else if (!q.ck_s2 && q.ck_s3 && q.cnt >= acr_pkg::HDR_BITS) begin
            d.miso = q.tx[7];
            d.tx   = {q.tx[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q       <= '0;
            q.cs_s1 <= 1'b1;
            q.cs_s2 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign spi_miso_o  = q.miso;
    assign spi_miso_oe = !q.cs_s2;
    assign reg_addr    = q.addr;
    assign reg_wdata   = q.wdata;
    assign reg_we      = q.we;
    assign reg_re      = q.re;
endmodule : acr_spi_slave

// [acr_sleep_timer.sv]
`timescale 1ns/1ps
// ****************************************************************
// Inter-cycle pause timer
// ****************************************************************
module acr_sleep_timer #(
    parameter int unsigned UNIT_CYCLES = acr_pkg::UNIT_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic       start,
    input  wire logic       cancel,
    input  wire logic [2:0] units,
    output logic            expired
);
    localparam int unsigned PW = $clog2(UNIT_CYCLES + 1);

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [2:0]    left;
        logic          run;
        logic          exp;
    } acr_tmr_t;

    acr_tmr_t q, d;
    logic     tick;

    // Prescaler gives one enable pulse per pause unit
    assign tick = (q.pre == PW'(UNIT_CYCLES - 1));

    always_comb begin
        d     = q;
        d.exp = 1'b0;
        if (start) begin
            d.run  = (units != 3'h0);
            d.left = units;
            d.pre  = '0;
        end else if (cancel) begin
            d.run = 1'b0;
        end else if (q.run) begin
            if (tick) begin
                d.pre = '0;
                if (q.left == 3'h1) begin
                    d.run = 1'b0;
                    d.exp = 1'b1;
                end else begin
                    d.left = q.left - 3'h1;
                end
            end else begin
                d.pre = q.pre + PW'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = q.exp;
endmodule : acr_sleep_timer

// [acr_adc_regs.sv]
`timescale 1ns/1ps
// Overview of operation
// - Channels 20 and 21 gain bits at control bits 2 and 3: one selects x10
// - Each slot high register bits 6:0 hold the seven result MSBs
// - High register bit 7 is per-channel gain: zero x1, one x10
// - Low register bits 2:0 hold three result LSBs; bits 7:3 reserved
// - Selection bits 4:0 choose which channel 0..31 the slot samples
// - Selection bit 5 turns on X plus and X minus bias switches
// - Selection bit 6 turns on Y plus and Y minus bias switches
// - Another selection bit turns on X minus and Y plus bias together
// - Extended control at 0x1de resets 0x00; bit 0 routes supply to channel 22
// - Extended bit 1 lets channel 24 read charge current, off after reset
// - Extended bit 2 lets channel 25 read backup cell, off after reset
// - Extended bit 4 picks LSB weighting; bit 3 and upper bits reserved
// - Sleep field: 0 continuous, 1..6 times 4.5 ms pause, 7 no loop
// - Setting go starts round robin; clearing stops after current cycle
module acr_adc_regs #(
    parameter int unsigned UNIT_CYCLES = acr_pkg::UNIT_CYCLES
) (
    input  wire logic                       mclk,
    input  wire logic                       rstn,
    input  wire logic                       spi_cs_n,
    input  wire logic                       spi_sclk,
    input  wire logic                       spi_mosi,
    output logic                            spi_miso_o,
    output logic                            spi_miso_oe,
    output logic                            conv_start,
    output logic [4:0]                      conv_channel,
    output logic                            conv_gain,
    input  wire logic                       conv_done,
    input  wire logic [acr_pkg::RES_W-1:0]  conv_result,
    output logic                            x_axis_bias_on,
    output logic                            y_axis_bias_on,
    output logic                            cross_bias_on,
    output logic                            supply_sense_en,
    output logic                            charge_current_sense_en,
    output logic                            backup_cell_sense_en,
    output logic                            lsb_weight_sel,
    output logic                            cycle_done,
    output logic                            rr_busy
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [31:0]       slot_gain_sel;
        logic [31:0][6:0]  result_msbs;
        logic [31:0][2:0]  result_lsbs;
        logic [31:0][7:0]  sel;
        logic              ch20_gain_sel;
        logic              ch21_gain_sel;
        logic              supply_sense_en;
        logic              charge_current_sense_en;
        logic              backup_cell_sense_en;
        logic              lsb_weight_sel;
        logic [2:0]        cycle_sleep_sel;
        logic              round_robin_go;
        logic              go_prev;
        acr_pkg::acr_state_t st;
        logic [4:0]        slot;
        logic              conv_start;
        logic [4:0]        ch;
        logic              cgain;
        logic              xb, yb, cb;
        logic              cyc_done;
        logic              tstart;
    } acr_regs_t;

    acr_regs_t q, d;

    logic [9:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_we;
    logic       reg_re;
    logic       expired;
    logic [4:0] idx;
    logic [4:0] nch;
    logic [7:0] nsel;

    // ****************************************************************
    // Submodules
    // ****************************************************************
    acr_spi_slave u_spi (
        .mclk        (mclk),
        .rstn        (rstn),
        .spi_cs_n    (spi_cs_n),
        .spi_sclk    (spi_sclk),
        .spi_mosi    (spi_mosi),
        .spi_miso_o  (spi_miso_o),
        .spi_miso_oe (spi_miso_oe),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_we      (reg_we),
        .reg_re      (reg_re),
        .reg_rdata   (reg_rdata)
    );

    acr_sleep_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_tmr (
        .mclk    (mclk),
        .rstn    (rstn),
        .start   (q.tstart),
        .cancel  (!q.round_robin_go),
        .units   (q.cycle_sleep_sel),
        .expired (expired)
    );

    assign idx = reg_addr[4:0];

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Unmapped addresses and reserved bits read zero
    always_comb begin
        reg_rdata = acr_pkg::READ_ZERO;
        if (reg_addr == acr_pkg::ADDR_CTRL2) begin
            reg_rdata[acr_pkg::SLEEP_W-1:0] = q.cycle_sleep_sel;
            reg_rdata[acr_pkg::GO_BIT]      = q.round_robin_go;
        end else if (reg_addr == acr_pkg::ADDR_GAIN4) begin
            reg_rdata[acr_pkg::CH20_GAIN_BIT] = q.ch20_gain_sel;
            reg_rdata[acr_pkg::CH21_GAIN_BIT] = q.ch21_gain_sel;
        end else if (reg_addr == acr_pkg::ADDR_EXT) begin
            reg_rdata[acr_pkg::SUPPLY_BIT] = q.supply_sense_en;
            reg_rdata[acr_pkg::CHARGE_BIT] = q.charge_current_sense_en;
            reg_rdata[acr_pkg::BACKUP_BIT] = q.backup_cell_sense_en;
            reg_rdata[acr_pkg::LSBW_BIT]   = q.lsb_weight_sel;
        end else if (reg_addr[9:5] == acr_pkg::BASE_HIGH_HI) begin
            reg_rdata = {q.slot_gain_sel[idx], q.result_msbs[idx]};
        end else if (reg_addr[9:5] == acr_pkg::BASE_LOW_HI) begin
            reg_rdata[acr_pkg::RES_LSB_W-1:0] = q.result_lsbs[idx];
        end else if (reg_addr[9:5] == acr_pkg::BASE_SEL_HI) begin
            reg_rdata = q.sel[idx];
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d            = q;
        d.conv_start = 1'b0;
        d.cyc_done   = 1'b0;
        d.tstart     = 1'b0;
        d.go_prev    = q.round_robin_go;
        nsel         = q.sel[q.slot];
        nch          = nsel[acr_pkg::SEL_CH_W-1:0];

        if (reg_we) begin
            if (reg_addr == acr_pkg::ADDR_CTRL2) begin
                d.cycle_sleep_sel = reg_wdata[acr_pkg::SLEEP_W-1:0];
                d.round_robin_go  = reg_wdata[acr_pkg::GO_BIT];
            end else if (reg_addr == acr_pkg::ADDR_GAIN4) begin
                d.ch20_gain_sel = reg_wdata[acr_pkg::CH20_GAIN_BIT];
                d.ch21_gain_sel = reg_wdata[acr_pkg::CH21_GAIN_BIT];
            end else if (reg_addr == acr_pkg::ADDR_EXT) begin
                d.supply_sense_en         = reg_wdata[acr_pkg::SUPPLY_BIT];
                d.charge_current_sense_en = reg_wdata[acr_pkg::CHARGE_BIT];
                d.backup_cell_sense_en    = reg_wdata[acr_pkg::BACKUP_BIT];
                d.lsb_weight_sel          = reg_wdata[acr_pkg::LSBW_BIT];
            end else if (reg_addr[9:5] == acr_pkg::BASE_HIGH_HI) begin
                // Result bits are read-only; only the gain bit takes a write
                d.slot_gain_sel[idx] = reg_wdata[acr_pkg::SLOT_GAIN_BIT];
            end else if (reg_addr[9:5] == acr_pkg::BASE_SEL_HI) begin
                d.sel[idx] = reg_wdata;
            end
        end

        unique case (q.st)
            acr_pkg::ST_IDLE: begin
                d.xb = 1'b0;
                d.yb = 1'b0;
                d.cb = 1'b0;
                if (q.round_robin_go && !q.go_prev) begin
                    d.slot = 5'h00;
                    d.st   = acr_pkg::ST_REQ;
                end
            end
            acr_pkg::ST_REQ: begin
                d.conv_start = 1'b1;
                d.ch         = nch;
                d.cgain      = q.slot_gain_sel[nch]
                             | (nch == acr_pkg::CH_GAIN20 && q.ch20_gain_sel)
                             | (nch == acr_pkg::CH_GAIN21 && q.ch21_gain_sel);
                d.xb         = nsel[acr_pkg::SEL_X_BIT];
                d.yb         = nsel[acr_pkg::SEL_Y_BIT];
                d.cb         = nsel[acr_pkg::SEL_CROSS_BIT];
                d.st         = acr_pkg::ST_WAIT;
            end
            acr_pkg::ST_WAIT: begin
                if (conv_done) begin
                    // Both halves taken from one result word
                    d.result_msbs[q.slot] = conv_result[acr_pkg::RES_W-1 -: acr_pkg::RES_MSB_W];
                    d.result_lsbs[q.slot] = conv_result[acr_pkg::RES_LSB_W-1:0];
                    if (q.slot == acr_pkg::LAST_SLOT) begin
                        d.cyc_done = 1'b1;
                        d.slot     = 5'h00;
                        if (!q.round_robin_go
                            || q.cycle_sleep_sel == acr_pkg::SLEEP_NONE) begin
                            d.st = acr_pkg::ST_IDLE;
                        end else if (q.cycle_sleep_sel == acr_pkg::SLEEP_CONT) begin
                            d.st = acr_pkg::ST_REQ;
                        end else begin
                            d.tstart = 1'b1;
                            d.st     = acr_pkg::ST_PAUSE;
                        end
                    end else begin
                        d.slot = q.slot + 5'h01;
                        d.st   = acr_pkg::ST_REQ;
                    end
                end
            end
            acr_pkg::ST_PAUSE: begin
                // Bias switches released while sleeping to save current
                d.xb = 1'b0;
                d.yb = 1'b0;
                d.cb = 1'b0;
                if (!q.round_robin_go) begin
                    d.st = acr_pkg::ST_IDLE;
                end else if (expired) begin
                    d.st = acr_pkg::ST_REQ;
                end
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q    <= '0;
            q.st <= acr_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign conv_start              = q.conv_start;
    assign conv_channel            = q.ch;
    assign conv_gain               = q.cgain;
    assign x_axis_bias_on          = q.xb;
    assign y_axis_bias_on          = q.yb;
    assign cross_bias_on           = q.cb;
    assign supply_sense_en         = q.supply_sense_en;
    assign charge_current_sense_en = q.charge_current_sense_en;
    assign backup_cell_sense_en    = q.backup_cell_sense_en;
    assign lsb_weight_sel          = q.lsb_weight_sel;
    assign cycle_done              = q.cyc_done;
    assign rr_busy                 = (q.st != acr_pkg::ST_IDLE);
endmodule : acr_adc_regs

// [acr_adc_regs_props.sv]
`timescale 1ns/1ps
// ****************
// Port checks
// ****************
module acr_adc_regs_props (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       spi_cs_n,
    input wire logic       conv_start,
    input wire logic [4:0] conv_channel,
    input wire logic       conv_gain,
    input wire logic       conv_done,
    input wire logic       x_axis_bias_on,
    input wire logic       y_axis_bias_on,
    input wire logic       cross_bias_on,
    input wire logic       supply_sense_en,
    input wire logic       charge_current_sense_en,
    input wire logic       backup_cell_sense_en,
    input wire logic       lsb_weight_sel,
    input wire logic       cycle_done,
    input wire logic       rr_busy
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    chan_hold_a: assert property (!conv_start |-> $stable(conv_channel))
        else $error("channel moved without a start");
    gain_hold_a: assert property (!conv_start |-> $stable(conv_gain))
        else $error("gain moved without a start");
    x_bias_a: assert property ($rose(x_axis_bias_on) |-> conv_start)
        else $error("x bias rose outside a start");
    y_bias_a: assert property ($rose(y_axis_bias_on) |-> conv_start)
        else $error("y bias rose outside a start");
    cross_bias_a: assert property ($rose(cross_bias_on) |-> conv_start)
        else $error("cross bias rose outside a start");
    bias_idle_a: assert property (
        !rr_busy [*2] |-> !(x_axis_bias_on | y_axis_bias_on | cross_bias_on))
        else $error("bias left on while idle");
    done_pulse_a: assert property (cycle_done |=> !cycle_done)
        else $error("cycle done longer than one cycle");
    start_busy_a: assert property (conv_start |-> rr_busy)
        else $error("start while idle");
    next_slot_a: assert property (
        conv_done && rr_busy |-> ##[1:3] (conv_start || cycle_done || !rr_busy))
        else $error("no next start after a result");
    sense_quiet_a: assert property (spi_cs_n [*8] |-> $stable({supply_sense_en,
        charge_current_sense_en, backup_cell_sense_en, lsb_weight_sel}))
        else $error("sense enables moved outside a frame");
    cycle_c: cover property (cycle_done);
    cross_c: cover property (conv_start && cross_bias_on);
    lsb_c: cover property ($rose(lsb_weight_sel));
endmodule : acr_adc_regs_props

bind acr_adc_regs acr_adc_regs_props acr_adc_regs_props_i (.*);

// [acr_conv_model.sv]
`timescale 1ns/1ps
// ****************
// Converter model
// ****************
module acr_conv_model (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       conv_start,
    input wire logic [4:0] conv_channel,
    input wire logic       slow,
    output logic           conv_done,
    output logic [9:0]     conv_result
);
    logic       busy_q;
    logic [2:0] cnt_q;
    logic [4:0] ch_q;
    logic [9:0] junk_q;
    // Result bus churns between answers so stale data cannot pass
    assign conv_result = conv_done ? {ch_q, ~ch_q} : junk_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            cnt_q <= 3'h0;
            ch_q <= 5'h00;
            junk_q <= 10'h2a5;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            junk_q <= junk_q + 10'h155;
            if (conv_start) begin
                busy_q <= 1'b1;
                ch_q <= conv_channel;
                cnt_q <= slow ? 3'h5 : 3'h0;
            end else if (busy_q && cnt_q != 3'h0) begin
                cnt_q <= cnt_q - 3'h1;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                conv_done <= 1'b1;
            end
        end
    end
endmodule : acr_conv_model

// [test_acr_adc_regs.sv]
`timescale 1ns/1ps
// ****************
// Register and sequencer test
// ****************
module test_acr_adc_regs;
    // Short pause unit keeps the run brief
    localparam int unsigned UNIT = 20;
    logic        mclk, rstn, spi_cs_n, spi_sclk, spi_mosi, spi_miso_o, spi_miso_oe;
    logic        conv_start, conv_gain, conv_done, cycle_done, rr_busy;
    logic        slow = 1'b0;
    logic [4:0]  conv_channel;
    logic [9:0]  conv_result;
    logic        x_axis_bias_on, y_axis_bias_on, cross_bias_on, supply_sense_en;
    logic        charge_current_sense_en, backup_cell_sense_en, lsb_weight_sel;
    logic [7:0]  lf;
    logic [7:0]  sel [32];
    logic [31:0] gain;
    logic [1:0]  g2021;
    logic [4:0]  slot = 5'h00;
    int          n_fail;
    int          n_checks;
    acr_adc_regs #(.UNIT_CYCLES(UNIT)) acr_adc_regs_i (.*);
    acr_conv_model acr_conv_model_i (.*);
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : nxt
    function automatic logic gain_of(input logic [4:0] c);
        return gain[c] | (c == acr_pkg::CH_GAIN20 & g2021[0]) | (c == acr_pkg::CH_GAIN21 & g2021[1]);
    endfunction : gain_of
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : cmp_reg
    task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t pin got %h exp %h", $time, got, exp);
        end
    endtask : cmp_pin
    task automatic wait_for(input int w, input int lim, output int n);
        n = 0;
        #1;
        while (n < lim && !((w == 0) ? cycle_done === 1'b1 :
                (w == 1) ? conv_start === 1'b1 : rr_busy === 1'b0)) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= lim) begin
            n_fail++;
            $display("MISMATCH %0t wait %h limit %h", $time, w, lim);
            tally_and_finish;
        end
    endtask : wait_for
    task automatic spi(input logic we, input logic [9:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        logic [23:0] f;
        f = {we, a, 5'h00, d};
        q = 8'h00;
        @(posedge mclk);
        spi_cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_mosi <= f[i];
            repeat (4) @(posedge mclk);
            spi_sclk <= 1'b1;
            if (i < 8) q[i] = spi_miso_o;
            if (i == 0) cmp_pin({7'h00, spi_miso_oe}, 8'h01);
            repeat (4) @(posedge mclk);
            spi_sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        spi_cs_n <= 1'b1;
        // Idle data line flips so the device cannot lean on a held level
        spi_mosi <= ~f[0];
        repeat (4) @(posedge mclk);
        cmp_pin({7'h00, spi_miso_oe}, 8'h00);
    endtask : spi
    always @(posedge mclk) begin
        if (rstn === 1'b1 && conv_start === 1'b1) begin
            cmp_pin({conv_channel, conv_gain, x_axis_bias_on, y_axis_bias_on, cross_bias_on},
                {sel[slot][4:0], gain_of(sel[slot][4:0]), sel[slot][5], sel[slot][6], sel[slot][7]});
            slot <= slot + 5'h01;
            slow <= slot[0] ^ slot[2];
        end
    end
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial begin
        int n;
        logic [7:0] q;
        logic [7:0] v;
        logic [9:0] r;
        {rstn, spi_sclk, spi_mosi, gain, g2021} = '0;
        spi_cs_n = 1'b1;
        lf = 8'h46;
        n_fail = 0;
        n_checks = 0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        spi(1'b0, acr_pkg::ADDR_EXT, 8'h00, q);
        cmp_reg(q, acr_pkg::EXT_RESET);
        cmp_pin({4'h0, lsb_weight_sel, backup_cell_sense_en, charge_current_sense_en, supply_sense_en}, 8'h00);
        for (int k = 0; k < 5; k++) begin
            lf = nxt(lf);
            v = (k == 0) ? 8'hff : lf;
            spi(1'b1, acr_pkg::ADDR_EXT, v, q);
            spi(1'b0, acr_pkg::ADDR_EXT, 8'h00, q);
            cmp_reg(q, v & 8'h17);
            cmp_pin({4'h0, lsb_weight_sel, backup_cell_sense_en, charge_current_sense_en, supply_sense_en}, {4'h0, v[4], v[2:0]});
        end
        spi(1'b1, acr_pkg::ADDR_GAIN4, 8'hff, q);
        spi(1'b0, acr_pkg::ADDR_GAIN4, 8'h00, q);
        cmp_reg(q, 8'h0c);
        lf = nxt(lf);
        g2021 = lf[3:2];
        spi(1'b1, acr_pkg::ADDR_GAIN4, lf, q);
        for (int s = 0; s < 32; s++) begin
            lf = nxt(lf);
            sel[s] = (s == 0) ? 8'hf4 : (s == 1) ? 8'h15 : lf;
            spi(1'b1, {acr_pkg::BASE_SEL_HI, s[4:0]}, sel[s], q);
            spi(1'b0, {acr_pkg::BASE_SEL_HI, s[4:0]}, 8'h00, q);
            cmp_reg(q, sel[s]);
            lf = nxt(lf);
            gain[s] = lf[7];
            spi(1'b1, {acr_pkg::BASE_HIGH_HI, s[4:0]}, lf, q);
            spi(1'b0, {acr_pkg::BASE_HIGH_HI, s[4:0]}, 8'h00, q);
            cmp_reg(q, {gain[s], 7'h00});
        end
        spi(1'b1, 10'h3ff, 8'h5a, q);
        spi(1'b0, 10'h3ff, 8'h00, q);
        cmp_reg(q, acr_pkg::READ_ZERO);
        spi(1'b1, acr_pkg::ADDR_CTRL2, 8'h47, q);
        wait_for(0, 20000, n);
        wait_for(2, 10, n);
        for (int s = 0; s < 32; s++) begin
            r = {sel[s][4:0], ~sel[s][4:0]};
            spi(1'b0, {acr_pkg::BASE_HIGH_HI, s[4:0]}, 8'h00, q);
            cmp_reg(q, {gain[s], r[9:3]});
            spi(1'b1, {acr_pkg::BASE_LOW_HI, s[4:0]}, 8'hff, q);
            spi(1'b0, {acr_pkg::BASE_LOW_HI, s[4:0]}, 8'h00, q);
            cmp_reg(q, {5'h00, r[2:0]});
        end
        for (int c = 0; c < 7; c++) begin
            spi(1'b1, acr_pkg::ADDR_CTRL2, 8'h00, q);
            wait_for(2, 5000, n);
            spi(1'b1, acr_pkg::ADDR_CTRL2, 8'h40 | c[7:0], q);
            wait_for(0, 20000, n);
            wait_for(1, 1000, n);
            cmp_pin({7'h00, n >= c * UNIT && n <= c * UNIT + 6}, 8'h01);
        end
        tally_and_finish;
    end
endmodule : test_acr_adc_regs
